// ### scdp_pkg.sv
// Purpose: shared constants and types of the serial channel character datapath
// Assumes: APB byte addresses, one 32-bit word per register, data in low byte
// Notes: field positions are bit indices inside the low byte of each register
`default_nettype none
package scdp_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_COMMAND = 8'h00;
	localparam logic [7:0] ADDR_INT_CFG = 8'h04;
	localparam logic [7:0] ADDR_RX_PARAM = 8'h08;
	localparam logic [7:0] ADDR_MISC_MODE = 8'h0c;
	localparam logic [7:0] ADDR_TX_PARAM = 8'h10;
	localparam logic [7:0] ADDR_SYNC_LOW = 8'h14;
	localparam logic [7:0] ADDR_SYNC_HIGH = 8'h18;
	localparam logic [7:0] ADDR_TX_BUFFER = 8'h1c;
	localparam logic [7:0] ADDR_MAIN_STATUS = 8'h20;
	localparam logic [7:0] ADDR_SPECIAL_STATUS = 8'h24;
	localparam logic [7:0] ADDR_OPTION = 8'h28;
	localparam logic [7:0] ADDR_RX_BUFFER = 8'h2c;
	localparam logic [7:0] REG_RESET = 8'h00;
	// field positions
	localparam int CMD_ERR_RESET = 0;
	localparam int ICFG_PARITY_SPECIAL = 2;
	localparam int RXP_LEN_HI = 7;
	localparam int RXP_LEN_LO = 6;
	localparam int RXP_AUTO_EN = 5;
	localparam int RXP_ENABLE = 0;
	localparam int MODE_PARITY_EN = 0;
	localparam int MODE_PARITY_EVEN = 1;
	localparam int MODE_STOP_HI = 3;
	localparam int MODE_STOP_LO = 2;
	localparam int MODE_SYNC_HI = 5;
	localparam int MODE_SYNC_LO = 4;
	localparam int TXP_DTR = 7;
	localparam int TXP_LEN_HI = 6;
	localparam int TXP_LEN_LO = 5;
	localparam int TXP_ENABLE = 3;
	localparam int OPT_XTAL = 0;
	localparam int OPT_DMA_REQ = 1;
	localparam int OPT_SRC_HI = 3;
	localparam int OPT_SRC_LO = 2;
	localparam int MST_AVAIL = 0;
	localparam int MST_TX_EMPTY = 2;
	localparam int MST_CARRIER = 3;
	localparam int MST_HUNT = 4;
	localparam int SST_PARITY = 4;
	localparam int SST_OVERRUN = 5;
	localparam int SST_LOCKED = 6;
	// mode field values
	localparam logic [1:0] STOP_SYNC_MODES = 2'h0;
	localparam logic [1:0] SYNC_EXTERNAL = 2'h3;
	// synchronised pin vector positions
	localparam int PIN_RXCLK = 4;
	localparam int PIN_TXCLK = 3;
	localparam int PIN_RXDATA = 2;
	localparam int PIN_CARRIER = 1;
	localparam int PIN_FRAME = 0;
	localparam int PIN_W = 5;
	// datapath sizes
	localparam int RX_DEPTH = 3;
	localparam logic [1:0] RX_FULL = 2'h3;
	localparam int HIST_W = 16;
	localparam int SNAP_HI = 15;
	localparam int SNAP_LO = 8;
	localparam int NINE_HI = 14;
	localparam int NINE_LO = 7;
	localparam logic [3:0] BITS_MIN = 4'h5;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
	localparam logic MARK = 1'b1;

	typedef enum logic [1:0] {
		LEN5 = 2'b00,
		LEN6 = 2'b01,
		LEN7 = 2'b10,
		LEN8 = 2'b11
	} scdp_len_e;

	typedef enum logic [1:0] {
		SRC_BUFFER = 2'b00,
		SRC_SYNC_LOW = 2'b01,
		SRC_SYNC_HIGH = 2'b10
	} scdp_txsrc_e;

	typedef struct packed {
		logic parityErr;
		logic [7:0] data;
	} scdp_rx_entry_s;
endpackage
`default_nettype wire

// ### scdp_channel.sv
// Purpose: receive and transmit character datapath of one serial channel
// Assumes: clk 200 MHz; link clocks much slower, sampled and edge-detected here
// Notes: one wait-free access phase on APB; prdata prepared in the setup cycle
`timescale 1ns/100ps
`default_nettype none
module scdp_channel (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	input wire logic receiveClockPin,
	input wire logic transmitClockPin,
	input wire logic rxDataPin,
	output logic txDataPin,
	// modem pins
	input wire logic carrierDetectPin,
	input wire logic framePinIn,
	output logic framePinOut,
	output logic framePinOe,
	output logic readyRequestPin
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	function automatic logic [3:0] charBits(input scdp_pkg::scdp_len_e len);
		charBits = scdp_pkg::BITS_MIN + {2'h0, len};
	endfunction

	// leading ones over three zeros shorten a five-bit character
	function automatic logic [3:0] fiveBits(input logic [7:0] b);
		if (b[7:1] == 7'h78) begin
			fiveBits = 4'h1;
		end else if (b[7:2] == 6'h38) begin
			fiveBits = 4'h2;
		end else if (b[7:3] == 5'h18) begin
			fiveBits = 4'h3;
		end else if (b[7:4] == 4'h8) begin
			fiveBits = 4'h4;
		end else begin
			fiveBits = scdp_pkg::BITS_MIN;
		end
	endfunction

	// pin synchronisers: a level counts once stages two and three agree
	logic [scdp_pkg::PIN_W-1:0] pinIn, s1_q, s2_q, s3_q, lvl_q, lvl_d;
	assign pinIn = {receiveClockPin, transmitClockPin, rxDataPin, carrierDetectPin, framePinIn};
	assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
	always_ff @(posedge clk) begin
		s1_q <= pinIn;
		s2_q <= s1_q;
		s3_q <= s2_q;
		// reset to the settled pin level so no false edge follows reset
		lvl_q <= rst_n ? lvl_d : s3_q;
	end
	logic rxRise, txFall, carrierLvl, frameLvl;
	assign rxRise = lvl_d[scdp_pkg::PIN_RXCLK] & ~lvl_q[scdp_pkg::PIN_RXCLK];
	assign txFall = ~lvl_d[scdp_pkg::PIN_TXCLK] & lvl_q[scdp_pkg::PIN_TXCLK];
	assign carrierLvl = lvl_q[scdp_pkg::PIN_CARRIER];
	assign frameLvl = lvl_q[scdp_pkg::PIN_FRAME];

	// software registers
	logic [7:0] intCfg_q, rxParam_q, mode_q, txParam_q, syncLow_q, syncHigh_q, txBuf_q, opt_q;
	logic pready_q, rdValid_q;
	logic apbSetup, apbAccess, wrAccess, rdAccess;
	assign apbSetup = psel & ~penable;
	assign apbAccess = psel & penable & pready_q;
	assign wrAccess = apbAccess & pwrite;
	assign rdAccess = apbAccess & ~pwrite;
	logic wrCmd, wrIcfg, wrRxp, wrMode, wrTxp, wrSyncLo, wrSyncHi, wrTxBuf, wrOpt;
	assign wrCmd = wrAccess & (paddr == scdp_pkg::ADDR_COMMAND);
	assign wrIcfg = wrAccess & (paddr == scdp_pkg::ADDR_INT_CFG);
	assign wrRxp = wrAccess & (paddr == scdp_pkg::ADDR_RX_PARAM);
	assign wrMode = wrAccess & (paddr == scdp_pkg::ADDR_MISC_MODE);
	assign wrTxp = wrAccess & (paddr == scdp_pkg::ADDR_TX_PARAM);
	assign wrSyncLo = wrAccess & (paddr == scdp_pkg::ADDR_SYNC_LOW);
	assign wrSyncHi = wrAccess & (paddr == scdp_pkg::ADDR_SYNC_HIGH);
	assign wrTxBuf = wrAccess & (paddr == scdp_pkg::ADDR_TX_BUFFER);
	assign wrOpt = wrAccess & (paddr == scdp_pkg::ADDR_OPTION);
	logic errReset, rdBuffer;
	assign errReset = wrCmd & pwdata[scdp_pkg::CMD_ERR_RESET];
	assign rdBuffer = rdAccess & (paddr == scdp_pkg::ADDR_RX_BUFFER) & rdValid_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			intCfg_q <= scdp_pkg::REG_RESET;
			rxParam_q <= scdp_pkg::REG_RESET;
			mode_q <= scdp_pkg::REG_RESET;
			txParam_q <= scdp_pkg::REG_RESET;
			syncLow_q <= scdp_pkg::REG_RESET;
			syncHigh_q <= scdp_pkg::REG_RESET;
			txBuf_q <= scdp_pkg::REG_RESET;
			opt_q <= scdp_pkg::REG_RESET;
		end else begin
			if (wrIcfg) intCfg_q <= pwdata[7:0];
			if (wrRxp) rxParam_q <= pwdata[7:0];
			if (wrMode) mode_q <= pwdata[7:0];
			if (wrTxp) txParam_q <= pwdata[7:0];
			if (wrSyncLo) syncLow_q <= pwdata[7:0];
			if (wrSyncHi) syncHigh_q <= pwdata[7:0];
			if (wrTxBuf) txBuf_q <= pwdata[7:0];
			if (wrOpt) opt_q <= pwdata[7:0];
		end
	end

	// mode decode
	logic parEn, parEven, syncModes, frameOutWanted, rxOn, rxGated;
	scdp_pkg::scdp_len_e rxLen, txLen;
	scdp_pkg::scdp_txsrc_e txSrc;
	assign parEn = mode_q[scdp_pkg::MODE_PARITY_EN];
	assign parEven = mode_q[scdp_pkg::MODE_PARITY_EVEN];
	assign syncModes = mode_q[scdp_pkg::MODE_STOP_HI:scdp_pkg::MODE_STOP_LO]
		== scdp_pkg::STOP_SYNC_MODES;
	assign frameOutWanted = syncModes
		& (mode_q[scdp_pkg::MODE_SYNC_HI:scdp_pkg::MODE_SYNC_LO] != scdp_pkg::SYNC_EXTERNAL);
	assign rxLen = scdp_pkg::scdp_len_e'(rxParam_q[scdp_pkg::RXP_LEN_HI:scdp_pkg::RXP_LEN_LO]);
	assign txLen = scdp_pkg::scdp_len_e'(txParam_q[scdp_pkg::TXP_LEN_HI:scdp_pkg::TXP_LEN_LO]);
	assign txSrc = scdp_pkg::scdp_txsrc_e'(opt_q[scdp_pkg::OPT_SRC_HI:scdp_pkg::OPT_SRC_LO]);
	assign rxGated = rxParam_q[scdp_pkg::RXP_AUTO_EN] & carrierLvl;
	assign rxOn = rxParam_q[scdp_pkg::RXP_ENABLE] & ~rxGated;

	// receive assembly
	logic rxSample_q, parAcc_q, pendErr_q, pendNine_q, rxPushReq_q;
	logic [3:0] bitCnt_q, pendLeft_q;
	logic [scdp_pkg::HIST_W-1:0] hist_q, histD;
	scdp_pkg::scdp_rx_entry_s rxPushEntry_q, pushEntry;
	logic bitNew, doneNow, nine, errNow, pushNow, pushLate;
	logic [3:0] rxTotal, bitCntInc, waitBits;
	assign bitNew = rxSample_q;
	assign histD = {bitNew, hist_q[scdp_pkg::HIST_W-1:1]};
	assign rxTotal = charBits(rxLen) + {3'h0, parEn};
	assign bitCntInc = bitCnt_q + 4'h1;
	assign doneNow = rxRise & rxOn & (bitCntInc >= rxTotal);
	assign nine = rxTotal == scdp_pkg::BITS_NINE;
	assign waitBits = nine ? 4'h0 : scdp_pkg::BITS_BYTE - rxTotal;
	assign errNow = parEn & (parAcc_q ^ bitNew ^ ~parEven);
	assign pushNow = doneNow & (waitBits == 4'h0);
	assign pushLate = rxRise & ~doneNow & (pendLeft_q == 4'h1);
	// trailing stream bits fill the top of a short character
	logic [7:0] pushData;
	logic pushErr;
	assign pushData = (pushNow ? nine : pendNine_q)
		? histD[scdp_pkg::NINE_HI:scdp_pkg::NINE_LO]
		: histD[scdp_pkg::SNAP_HI:scdp_pkg::SNAP_LO];
	assign pushErr = pushNow ? errNow : pendErr_q;
	assign pushEntry = {pushErr, pushData};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxSample_q <= scdp_pkg::MARK;
			hist_q <= '0;
			bitCnt_q <= 4'h0;
			parAcc_q <= 1'b0;
			pendLeft_q <= 4'h0;
			pendErr_q <= 1'b0;
			pendNine_q <= 1'b0;
			rxPushReq_q <= 1'b0;
			rxPushEntry_q <= '0;
		end else begin
			rxPushReq_q <= pushNow | pushLate;
			rxPushEntry_q <= pushEntry;
			if (rxRise) begin
				rxSample_q <= lvl_q[scdp_pkg::PIN_RXDATA];
				hist_q <= histD;
				if (doneNow) begin
					bitCnt_q <= 4'h0;
					parAcc_q <= 1'b0;
					pendLeft_q <= waitBits;
					pendErr_q <= errNow;
					pendNine_q <= nine;
				end else begin
					bitCnt_q <= rxOn ? bitCntInc : 4'h0;
					parAcc_q <= rxOn & (parAcc_q ^ bitNew);
					if (pendLeft_q != 4'h0) pendLeft_q <= pendLeft_q - 4'h1;
				end
			end
		end
	end

	// receive fifo with per-entry status, top at index 0
	scdp_pkg::scdp_rx_entry_s fifo_q [scdp_pkg::RX_DEPTH];
	scdp_pkg::scdp_rx_entry_s fifoD [scdp_pkg::RX_DEPTH];
	logic [1:0] cnt_q, cntD;
	logic lock_q, overrun_q, special, popTop, clearTopErr, pushDrop;
	assign special = fifo_q[0].parityErr & intCfg_q[scdp_pkg::ICFG_PARITY_SPECIAL];
	assign popTop = (rdBuffer & ~lock_q & ~special) | (errReset & lock_q);
	assign clearTopErr = errReset & ~lock_q;
	always_comb begin
		fifoD = fifo_q;
		cntD = cnt_q;
		pushDrop = 1'b0;
		if (popTop) begin
			for (int i = 0; i < scdp_pkg::RX_DEPTH - 1; i++) begin
				fifoD[i] = fifo_q[i + 1];
			end
			// vacated slot must not show stale status once it reaches the top
			fifoD[scdp_pkg::RX_DEPTH - 1] = '0;
			cntD = cnt_q - 2'h1;
		end
		if (clearTopErr) fifoD[0].parityErr = 1'b0;
		if (rxPushReq_q) begin
			if (cntD == scdp_pkg::RX_FULL) begin
				pushDrop = 1'b1;
			end else begin
				fifoD[cntD] = rxPushEntry_q;
				cntD = cntD + 2'h1;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 2'h0;
			lock_q <= 1'b0;
			overrun_q <= 1'b0;
			for (int i = 0; i < scdp_pkg::RX_DEPTH; i++) fifo_q[i] <= '0;
		end else begin
			fifo_q <= fifoD;
			cnt_q <= cntD;
			// the flagged character stays on top while the lock holds
			if (rdBuffer & special) lock_q <= 1'b1;
			else if (errReset) lock_q <= 1'b0;
			// a drop in the clearing cycle still sets overrun
			overrun_q <= pushDrop | (overrun_q & ~errReset);
		end
	end

	// transmitter
	logic txFull_q, txOut_q;
	logic [7:0] txShift_q, loadByte;
	logic [3:0] txLeft_q, loadCount;
	logic txEn, txIdle, loadBuf, loadSync, txLoad;
	assign txEn = txParam_q[scdp_pkg::TXP_ENABLE];
	assign txIdle = txLeft_q == 4'h0;
	assign loadBuf = txFall & txIdle & txEn & txFull_q;
	assign loadSync = txFall & txIdle & txEn & ~txFull_q & (txSrc != scdp_pkg::SRC_BUFFER);
	assign txLoad = loadBuf | loadSync;
	assign loadByte = loadBuf ? txBuf_q
		: ((txSrc == scdp_pkg::SRC_SYNC_LOW) ? syncLow_q : syncHigh_q);
	// length taken at the move, so a later change waits for the next character
	assign loadCount = (txLen == scdp_pkg::LEN5) ? fiveBits(loadByte) : charBits(txLen);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txFull_q <= 1'b0;
			txOut_q <= scdp_pkg::MARK;
			txShift_q <= 8'h00;
			txLeft_q <= 4'h0;
		end else begin
			// a write in the move cycle refills the buffer
			txFull_q <= wrTxBuf | (txFull_q & ~loadBuf);
			if (txLoad) begin
				txOut_q <= loadByte[0];
				txShift_q <= {1'b0, loadByte[7:1]};
				txLeft_q <= loadCount - 4'h1;
			end else if (txFall & ~txIdle) begin
				txOut_q <= txShift_q[0];
				txShift_q <= {1'b0, txShift_q[7:1]};
				txLeft_q <= txLeft_q - 4'h1;
			end else if (txFall) begin
				txOut_q <= scdp_pkg::MARK;
			end
		end
	end

	// status and modem pins
	logic huntFlag, dtrBit;
	logic [7:0] mainStatus, specialStatus, rdMux;
	assign huntFlag = ~opt_q[scdp_pkg::OPT_XTAL] & ~frameOutWanted & frameLvl;
	assign dtrBit = txParam_q[scdp_pkg::TXP_DTR];
	always_comb begin
		mainStatus = 8'h00;
		mainStatus[scdp_pkg::MST_AVAIL] = cnt_q != 2'h0;
		mainStatus[scdp_pkg::MST_TX_EMPTY] = ~txFull_q;
		mainStatus[scdp_pkg::MST_CARRIER] = carrierLvl;
		mainStatus[scdp_pkg::MST_HUNT] = huntFlag;
		specialStatus = 8'h00;
		specialStatus[scdp_pkg::SST_PARITY] = fifo_q[0].parityErr;
		specialStatus[scdp_pkg::SST_OVERRUN] = overrun_q;
		specialStatus[scdp_pkg::SST_LOCKED] = lock_q;
	end
	logic addrKnown;
	assign addrKnown = (paddr[1:0] == 2'h0) & (paddr <= scdp_pkg::ADDR_RX_BUFFER);
	assign rdMux = (paddr == scdp_pkg::ADDR_INT_CFG) ? intCfg_q
		: (paddr == scdp_pkg::ADDR_RX_PARAM) ? rxParam_q
		: (paddr == scdp_pkg::ADDR_MISC_MODE) ? mode_q
		: (paddr == scdp_pkg::ADDR_TX_PARAM) ? txParam_q
		: (paddr == scdp_pkg::ADDR_SYNC_LOW) ? syncLow_q
		: (paddr == scdp_pkg::ADDR_SYNC_HIGH) ? syncHigh_q
		: (paddr == scdp_pkg::ADDR_MAIN_STATUS) ? mainStatus
		: (paddr == scdp_pkg::ADDR_SPECIAL_STATUS) ? specialStatus
		: (paddr == scdp_pkg::ADDR_OPTION) ? opt_q
		: (paddr == scdp_pkg::ADDR_RX_BUFFER) ? fifo_q[0].data
		: 8'h00;

	// output flops; read data is captured in setup so the access needs no wait
	logic [31:0] prdata_q;
	logic pslverr_q, frameOut_q, frameOe_q, readyReq_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			rdValid_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			frameOut_q <= 1'b0;
			frameOe_q <= 1'b0;
			readyReq_q <= 1'b1;
		end else begin
			pready_q <= apbSetup;
			if (apbSetup) begin
				prdata_q <= {24'h00_0000, rdMux};
				pslverr_q <= ~addrKnown;
				rdValid_q <= cnt_q != 2'h0;
			end
			frameOe_q <= frameOutWanted;
			frameOut_q <= rxPushReq_q;
			// with the request option set the pin is active low while a character waits; otherwise it is the inverse of dtrBit
			readyReq_q <= opt_q[scdp_pkg::OPT_DMA_REQ] ? (cnt_q == 2'h0) : ~dtrBit;
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign txDataPin = txOut_q;
	assign framePinOut = frameOut_q;
	assign framePinOe = frameOe_q;
	assign readyRequestPin = readyReq_q;

	a_fifo_bound: assert property (pushDrop |=> cnt_q == scdp_pkg::RX_FULL && overrun_q)
		else $error("dropped character without full fifo and overrun");
	a_push_avail: assert property (rxPushReq_q && !popTop |=> cnt_q != 2'h0)
		else $error("pushed character not available");
	a_read_pop: assert property (rdBuffer && !lock_q && !special && !rxPushReq_q
		|=> cnt_q == $past(cnt_q) - 2'h1)
		else $error("unlocked read did not advance fifo");
	a_lock_hold: assert property (lock_q && !errReset && !rxPushReq_q
		|=> lock_q && $stable(cnt_q))
		else $error("locked fifo changed without error reset");
	a_lock_set: assert property (rdBuffer && special |=> lock_q ##0 fifo_q[0].parityErr)
		else $error("special condition read did not lock");
	a_reset_unlock: assert property (errReset |=> !lock_q)
		else $error("error reset left fifo locked");
	a_tx_move: assert property (loadBuf && !wrTxBuf |=> !txFull_q ##0 (txDataPin
		== $past(txBuf_q[0])))
		else $error("move did not empty buffer or send lsb");
	a_tx_count: assert property (txLoad && loadCount == 4'h1 |=> txIdle)
		else $error("one-bit character kept shifting");
	a_tx_idle: assert property (txFall && txIdle && !txLoad |=> txDataPin)
		else $error("idle line not marking");
	a_rx_gated: assert property (rxRise && rxGated |=> bitCnt_q == 4'h0)
		else $error("gated receiver kept assembling");
	a_dtr_pin: assert property (!opt_q[scdp_pkg::OPT_DMA_REQ] |=> readyRequestPin
		== !$past(dtrBit))
		else $error("ready pin not inverse of control bit");
	a_hunt_xtal: assert property (opt_q[scdp_pkg::OPT_XTAL] |-> !mainStatus[scdp_pkg::MST_HUNT])
		else $error("hunt flag set with crystal enabled");
endmodule
`default_nettype wire

// ### scdp_line_model.sv
// Purpose: serial line model for the channel datapath
// Assumes: bit period 160 ns on both link clocks
// Notes: clocks stand still between frames; released data shows the inverse of its last bit
`timescale 1ns/100ps
`default_nettype none
module scdp_line_model (
	// serial link
	output logic rxClk,
	output logic txClk,
	output logic rxData,
	input wire logic txData
);
	initial begin
		rxClk = 1'b0;
		txClk = 1'b1;
		rxData = 1'b1;
	end
	// lsb first, data held a half period on each side of the rise
	task automatic send(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			rxData = b[i[2:0]];
			#80 rxClk = 1'b1;
			#80 rxClk = 1'b0;
		end
		rxData = ~rxData;
	endtask
	// data moves on the fall, so it is taken mid-bit on the rise
	task automatic take(output logic [7:0] b, input int n);
		b = 8'h00;
		for (int i = 0; i < n; i++) begin
			#80 txClk = 1'b0;
			#80 txClk = 1'b1;
			if (i < 8) begin
				b[i[2:0]] = txData;
			end
		end
	endtask
endmodule
`default_nettype wire

// ### serial_channel_char_datapath_bench.sv
// Purpose: self-checking bench of the channel datapath
// Assumes: wait-free apb slave, line model on the serial side
// Notes: the rx stream never reframes, so the tests keep bit alignment in order
`timescale 1ns/100ps
`default_nettype none
module serial_channel_char_datapath_bench;
	localparam logic [7:0] A_CMD = scdp_pkg::ADDR_COMMAND;
	localparam logic [7:0] A_ICFG = scdp_pkg::ADDR_INT_CFG;
	localparam logic [7:0] A_RXP = scdp_pkg::ADDR_RX_PARAM;
	localparam logic [7:0] A_MODE = scdp_pkg::ADDR_MISC_MODE;
	localparam logic [7:0] A_TXP = scdp_pkg::ADDR_TX_PARAM;
	localparam logic [7:0] A_SYL = scdp_pkg::ADDR_SYNC_LOW;
	localparam logic [7:0] A_SYH = scdp_pkg::ADDR_SYNC_HIGH;
	localparam logic [7:0] A_TXB = scdp_pkg::ADDR_TX_BUFFER;
	localparam logic [7:0] A_MST = scdp_pkg::ADDR_MAIN_STATUS;
	localparam logic [7:0] A_SST = scdp_pkg::ADDR_SPECIAL_STATUS;
	localparam logic [7:0] A_OPT = scdp_pkg::ADDR_OPTION;
	localparam logic [7:0] A_RXB = scdp_pkg::ADDR_RX_BUFFER;
	localparam logic [7:0] TXP [5] = '{8'h68, 8'h28, 8'h08, 8'h08, 8'h08};
	localparam logic [7:0] TXD [5] = '{8'ha5, 8'h45, 8'hf1, 8'h1a, 8'hc5};
	localparam logic [7:0] TXE [5] = '{8'ha5, 8'hc5, 8'hff, 8'hfa, 8'hfd};
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic rxClk, txClk, rxData, txData, carrier, frameIn, frameOut, frameOe, readyReq;
	logic [7:0] paddr, tb;
	logic [31:0] pwdata, prdata, rd;
	int miscompares = 0;
	int numChecks = 0;
	int framePulses = 0;
	always @(posedge clk) if (frameOut === 1'b1) framePulses++;
	always #2.5 clk = ~clk;
	scdp_channel DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .receiveClockPin(rxClk),
		.transmitClockPin(txClk), .rxDataPin(rxData), .txDataPin(txData),
		.carrierDetectPin(carrier), .framePinIn(frameIn), .framePinOut(frameOut),
		.framePinOe(frameOe), .readyRequestPin(readyReq));
	scdp_line_model line (.rxClk(rxClk), .txClk(txClk), .rxData(rxData), .txData(txData));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (miscompares == 0 && numChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// one transfer; the leading edge keeps back-to-back calls apart
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			miscompares++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, {24'h0, d}, q, e);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] q;
		logic x;
		apb(1'b0, a, 32'h0, q, x);
		check(q & {24'h0, m}, {24'h0, e});
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		finish_test();
	end
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		carrier = 1'b0;
		frameIn = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, 8'h3c, 32'h0, rd, err);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		// ready pin follows the inverse of the ready bit
		wr(A_TXP, 8'h88);
		repeat (2) @(posedge clk);
		check({31'h0, readyReq}, 32'h0);
		wr(A_TXP, 8'h68);
		repeat (2) @(posedge clk);
		check({31'h0, readyReq}, 32'h1);
		frameIn <= 1'b1;
		wr(A_MODE, 8'h04);
		repeat (8) @(posedge clk);
		rc(A_MST, 8'h10, 8'h10);
		wr(A_OPT, 8'h01);
		rc(A_MST, 8'h10, 8'h00);
		wr(A_OPT, 8'h00);
		wr(A_MODE, 8'h00);
		repeat (2) @(posedge clk);
		check({31'h0, frameOe}, 32'h1);
		wr(A_MODE, 8'h30);
		repeat (2) @(posedge clk);
		check({31'h0, frameOe}, 32'h0);
		// len7 even parity; the fourth character finds the fifo full
		wr(A_MODE, 8'h07);
		wr(A_ICFG, 8'h04);
		wr(A_RXP, 8'h81);
		// the reset sample, a mark, is assembled first and stands for bit 0 of 0x41
		line.send(8'h20, 7);
		line.send(8'h87, 8);
		line.send(8'h83, 8);
		line.send(8'h55, 8);
		line.send(8'h00, 1);
		repeat (8) @(posedge clk);
		check(framePulses, 32'h4);
		rc(A_MST, 8'h01, 8'h01);
		rc(A_SST, 8'h10, 8'h00);
		rc(A_RXB, 8'hff, 8'h41);
		rc(A_SST, 8'h10, 8'h00);
		rc(A_RXB, 8'hff, 8'h87);
		rc(A_SST, 8'h10, 8'h10);
		rc(A_RXB, 8'hff, 8'h83);
		rc(A_SST, 8'h70, 8'h70);
		rc(A_RXB, 8'hff, 8'h83);
		wr(A_CMD, 8'h01);
		rc(A_SST, 8'h70, 8'h00);
		rc(A_MST, 8'h01, 8'h00);
		// length cut to five while the next character is under way
		wr(A_MODE, 8'h04);
		wr(A_RXP, 8'hc1);
		line.send(8'h73, 3);
		wr(A_RXP, 8'h01);
		line.send(8'h0e, 4);
		line.send(8'h00, 1);
		repeat (8) @(posedge clk);
		rc(A_RXB, 8'hff, 8'he6);
		carrier <= 1'b1;
		wr(A_RXP, 8'h21);
		line.send(8'hff, 8);
		line.send(8'hff, 8);
		repeat (8) @(posedge clk);
		rc(A_MST, 8'h09, 8'h08);
		carrier <= 1'b0;
		repeat (8) @(posedge clk);
		line.send(8'hff, 8);
		line.send(8'hff, 8);
		repeat (8) @(posedge clk);
		rc(A_MST, 8'h09, 8'h01);
		// request mode: pin low while characters wait
		wr(A_OPT, 8'h02);
		repeat (2) @(posedge clk);
		check({31'h0, readyReq}, 32'h0);
		wr(A_OPT, 8'h00);
		// length set before each buffer write; two idle falls flush the shifter
		for (int i = 0; i < 5; i++) begin
			wr(A_TXP, TXP[i]);
			wr(A_TXB, TXD[i]);
			rc(A_MST, 8'h04, 8'h00);
			line.take(tb, 10);
			check({24'h0, tb}, {24'h0, TXE[i]});
			rc(A_MST, 8'h04, 8'h04);
		end
		wr(A_TXP, 8'h68);
		wr(A_SYL, 8'h96);
		wr(A_OPT, 8'h04);
		line.take(tb, 8);
		check({24'h0, tb}, 32'h96);
		wr(A_SYH, 8'h3c);
		wr(A_OPT, 8'h08);
		line.take(tb, 8);
		check({24'h0, tb}, 32'h3c);
		wr(A_OPT, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
